// >>> ebpfs_top.sv
// external bus pin function select with apb register access
`timescale 1ns/100ps
//
// Contract
// [RULE1] eight-bit bus: upper data pins are ports
// [RULE2] sixteen-bit bus: upper data pins carry data
// [RULE3] middle address pins selected bit by bit
// [RULE4] upper address pin drives address when selected
// [RULE5] transmit output overrides address bit nineteen pin
// [RULE6] bit twenty pin shared with serial clocks
// [RULE7] second serial data output overrides bit twentyone
// [RULE8] inputs sample pins continuously while operating
// [RULE9] software disables outputs on input-function pins
// [RULE10] ready enabled: pin is ready input
// [RULE11] hold enabled: request input, acknowledge output
// [RULE12] upper write strobe needs sixteen-bit mode, enable
// [RULE13] lower write strobe drives pin when enabled
// [RULE14] port pins follow port data and direction
module ebpfs_top
    import ebpfs_pkg::*;
(
    // clock, reset, enable
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // shared pins
    input  wire logic [PIN_COUNT-1:0] pin_i,
    output logic      [PIN_COUNT-1:0] pin_o,
    output logic      [PIN_COUNT-1:0] pin_oe,
    // port data and direction, one bit per pin
    input  wire logic [PIN_COUNT-1:0] port_data,
    input  wire logic [PIN_COUNT-1:0] port_dir,
    output logic      [PIN_COUNT-1:0] port_level,
    // external bus controller
    input  wire logic [23:8]          bus_addr,
    input  wire logic [7:0]           upper_data_bus_byte_o,
    input  wire logic                 upper_data_bus_byte_oe,
    output logic      [7:0]           upper_data_bus_byte_i,
    input  wire logic                 upper_byte_write_strobe,
    input  wire logic                 lower_byte_write_strobe,
    input  wire logic                 bus_hold_acknowledge_out,
    output logic                      bus_ready_in,
    output logic                      bus_hold_request_in,
    // serial units
    input  wire logic                 async_serial_tx_out,
    input  wire logic                 async_serial_tx_oe,
    input  wire logic                 async_serial_clock_o,
    input  wire logic                 async_serial_clock_oe,
    output logic                      async_serial_clock_i,
    output logic                      async_serial_rx_in,
    input  wire logic                 second_sync_serial_unit_clock_o,
    input  wire logic                 second_sync_serial_unit_clock_oe,
    input  wire logic                 second_sync_serial_unit_data_o,
    input  wire logic                 second_sync_serial_unit_data_oe,
    // capture and timer inputs on upper address bits 21..23
    output logic      [2:0]           capture_timer_in
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    ebpfs_apb_state_type        state_q;
    logic [CTRL_WIDTH-1:0]      ctrl_q;
    logic [7:0]                 maddr_q;
    logic [7:0]                 uaddr_q;
    logic [PIN_COUNT-1:0]       func_sel_q;
    logic [PIN_COUNT-1:0]       func_sel_d;
    logic [PIN_COUNT-1:0]       func_o_d;
    logic [PIN_COUNT-1:0]       func_oe_d;
    logic [PIN_COUNT-1:0]       level_q;
    logic [31:0]                rdata_d;
    logic                       err_d;
    logic                       wr_en;
    logic                       bus16;

    assign bus16 = ctrl_q[CTRL_BUS16];

    // word-aligned decode, shared by read and write paths
    function automatic logic ebpfs_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction : ebpfs_hit

    // ----------------------------------------------------------------
    // apb slave: answer in the first access cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            state_q <= EBPFS_IDLE;
        else if (clk_en)
        begin
            case (state_q)
                EBPFS_IDLE:
                    if (psel && !penable)
                        state_q <= EBPFS_ANSWER;
                EBPFS_ANSWER:
                    state_q <= EBPFS_IDLE;
                default:
                    state_q <= EBPFS_IDLE;
            endcase
        end
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        if (ebpfs_hit(paddr, OFS_CTRL))
            rdata_d = 32'(ctrl_q);
        else if (ebpfs_hit(paddr, OFS_MADDR))
            rdata_d = 32'(maddr_q);
        else if (ebpfs_hit(paddr, OFS_UADDR))
            rdata_d = 32'(uaddr_q);
        else if (ebpfs_hit(paddr, OFS_LEVEL))
            rdata_d = 32'(level_q);
        else if (ebpfs_hit(paddr, OFS_FUNC))
            rdata_d = 32'(func_sel_q);
        else
            err_d = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready  <= (state_q == EBPFS_IDLE) && psel && !penable;
            prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr <= (state_q == EBPFS_IDLE) && psel && !penable && err_d;
        end
    end

    assign wr_en = (state_q == EBPFS_ANSWER) && psel && penable && pwrite && pready;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ctrl_q  <= CTRL_RST;
            maddr_q <= MADDR_RST;
            uaddr_q <= UADDR_RST;
        end
        else if (clk_en && wr_en)
        begin
            if (ebpfs_hit(paddr, OFS_CTRL))
                ctrl_q <= pwdata[CTRL_WIDTH-1:0];
            if (ebpfs_hit(paddr, OFS_MADDR))
                maddr_q <= pwdata[7:0];
            if (ebpfs_hit(paddr, OFS_UADDR))
                uaddr_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // function selection per pin
    // ----------------------------------------------------------------
    always_comb
    begin
        func_sel_d = '0;
        func_o_d   = '0;
        func_oe_d  = '0;
        // upper data byte only exists on a sixteen-bit bus
        for (int i = 0; i < 8; i++)
        begin
            func_sel_d[UDATA_BASE+i] = bus16;                      // RULE1 RULE2
            func_o_d[UDATA_BASE+i]   = upper_data_bus_byte_o[i];   // RULE2
            func_oe_d[UDATA_BASE+i]  = upper_data_bus_byte_oe;     // RULE2
            func_sel_d[MADDR_BASE+i] = maddr_q[i];                 // RULE3
            func_o_d[MADDR_BASE+i]   = bus_addr[8+i];              // RULE3
            func_oe_d[MADDR_BASE+i]  = 1'b1;
            func_sel_d[UADDR_BASE+i] = uaddr_q[i];                 // RULE4
            func_o_d[UADDR_BASE+i]   = bus_addr[16+i];             // RULE4
            func_oe_d[UADDR_BASE+i]  = 1'b1;
        end
        // transmit wins over both address and port use
        if (async_serial_tx_oe)
        begin
            func_sel_d[UADDR_BASE+UA_TX] = 1'b1;                   // RULE5
            func_o_d[UADDR_BASE+UA_TX]   = async_serial_tx_out;    // RULE5
        end
        // serial clock, then address, then second unit clock, then port
        if (async_serial_clock_oe)
        begin
            func_sel_d[UADDR_BASE+UA_SCK] = 1'b1;                  // RULE6
            func_o_d[UADDR_BASE+UA_SCK]   = async_serial_clock_o;  // RULE6
        end
        else if (!uaddr_q[UA_SCK] && second_sync_serial_unit_clock_oe)
        begin
            func_sel_d[UADDR_BASE+UA_SCK] = 1'b1;                  // RULE6
            func_o_d[UADDR_BASE+UA_SCK]   = second_sync_serial_unit_clock_o;
        end
        if (second_sync_serial_unit_data_oe)
        begin
            func_sel_d[UADDR_BASE+UA_SSI] = 1'b1;                  // RULE7
            func_o_d[UADDR_BASE+UA_SSI]   = second_sync_serial_unit_data_o;
        end
        // ready and hold request are inputs: selected, never driven
        func_sel_d[PIN_READY] = ctrl_q[CTRL_READY];                // RULE10
        func_sel_d[PIN_REQ]   = ctrl_q[CTRL_HOLD];                 // RULE11
        func_sel_d[PIN_ACK]   = ctrl_q[CTRL_HOLD];                 // RULE11
        func_o_d[PIN_ACK]     = bus_hold_acknowledge_out;          // RULE11
        func_oe_d[PIN_ACK]    = 1'b1;
        func_sel_d[PIN_UPSTB] = bus16 && ctrl_q[CTRL_UPSTB];       // RULE12
        func_o_d[PIN_UPSTB]   = upper_byte_write_strobe;
        func_oe_d[PIN_UPSTB]  = 1'b1;
        func_sel_d[PIN_LOSTB] = ctrl_q[CTRL_LOSTB];                // RULE13
        func_o_d[PIN_LOSTB]   = lower_byte_write_strobe;
        func_oe_d[PIN_LOSTB]  = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            func_sel_q <= '0;
        else if (clk_en)
            func_sel_q <= func_sel_d;
    end

    // ----------------------------------------------------------------
    // pin stages and level sampling
    // ----------------------------------------------------------------
    for (genvar g = 0; g < PIN_COUNT; g++)
    begin : g_cell
        ebpfs_pin_cell u_cell (
            .clock    (clock),
            .sys_rst  (sys_rst),
            .clk_en   (clk_en),
            .func_sel (func_sel_d[g]),
            .func_o   (func_o_d[g]),
            .func_oe  (func_oe_d[g]),
            .port_o   (port_data[g]),
            .port_oe  (port_dir[g]),
            .pin_o_q  (pin_o[g]),
            .pin_oe_q (pin_oe[g])
        );
    end

    ebpfs_level_sample #(
        .WIDTH (PIN_COUNT)
    ) u_sample (
        .clock   (clock),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .pin_i   (pin_i),
        .level_q (level_q)
    );

    // input functions see the pin whoever drives it
    assign port_level            = level_q;                                // RULE14
    assign upper_data_bus_byte_i = level_q[UDATA_BASE+7:UDATA_BASE];
    assign async_serial_rx_in    = level_q[UADDR_BASE+UA_RX];              // RULE8
    assign async_serial_clock_i  = level_q[UADDR_BASE+UA_SCK];
    assign capture_timer_in      = level_q[UADDR_BASE+7:UADDR_BASE+UA_CAP]; // RULE8

    // disabled ready reads as ready so the bus never stalls on a port pin
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            bus_ready_in        <= 1'b1;
            bus_hold_request_in <= 1'b0;
        end
        else if (clk_en)
        begin
            bus_ready_in        <= !ctrl_q[CTRL_READY] || level_q[PIN_READY]; // RULE10
            bus_hold_request_in <= ctrl_q[CTRL_HOLD] && level_q[PIN_REQ];     // RULE11
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_udata_port_mode: assert property (@(posedge clock) disable iff (sys_rst) // RULE1
        clk_en && !bus16 |=> pin_oe[7:0] == $past(port_dir[7:0]))
        else $error("upper data pins not ports in eight-bit mode");

    a_udata_bus_mode: assert property (@(posedge clock) disable iff (sys_rst) // RULE2
        clk_en && bus16 |=> pin_o[7:0] == $past(upper_data_bus_byte_o)
            && pin_oe[7:0] == {8{$past(upper_data_bus_byte_oe)}})
        else $error("upper data pins not on bus in sixteen-bit mode");

    a_mid_addr_sel: assert property (@(posedge clock) disable iff (sys_rst) // RULE3
        clk_en |=> pin_o[15:8] == (($past(maddr_q) & $past(bus_addr[15:8]))
            | (~$past(maddr_q) & $past(port_data[15:8]))))
        else $error("middle address pin selection wrong");

    a_tx_priority: assert property (@(posedge clock) disable iff (sys_rst) // RULE5
        clk_en && async_serial_tx_oe |=> pin_o[UADDR_BASE+UA_TX] == $past(async_serial_tx_out)
            && pin_oe[UADDR_BASE+UA_TX])
        else $error("transmit output not on shared pin");

    a_upper_addr: assert property (@(posedge clock) disable iff (sys_rst) // RULE4
        clk_en && uaddr_q[7] && !async_serial_tx_oe |=> pin_o[23] == $past(bus_addr[23]))
        else $error("upper address bit not driven");

    a_sck_share: assert property (@(posedge clock) disable iff (sys_rst) // RULE6
        clk_en && !async_serial_clock_oe && uaddr_q[UA_SCK]
            |=> pin_o[UADDR_BASE+UA_SCK] == $past(bus_addr[20]))
        else $error("address bit twenty lost to serial clock");

    a_ssi_data: assert property (@(posedge clock) disable iff (sys_rst) // RULE7
        clk_en && second_sync_serial_unit_data_oe
            |=> pin_o[UADDR_BASE+UA_SSI] == $past(second_sync_serial_unit_data_o))
        else $error("second serial data not on shared pin");

    sequence s_ready_taken;
        clk_en ##1 clk_en && ctrl_q[CTRL_READY];
    endsequence

    a_ready_input: assert property (@(posedge clock) disable iff (sys_rst) // RULE10
        s_ready_taken |=> bus_ready_in == $past(pin_i[PIN_READY], 2) && !pin_oe[PIN_READY])
        else $error("ready pin level not passed to bus");

    a_hold_ack: assert property (@(posedge clock) disable iff (sys_rst) // RULE11
        clk_en && ctrl_q[CTRL_HOLD] |=> pin_oe[PIN_ACK] && !pin_oe[PIN_REQ]
            && pin_o[PIN_ACK] == $past(bus_hold_acknowledge_out))
        else $error("hold pins not in hold function");

    a_upper_strobe_gate: assert property (@(posedge clock) disable iff (sys_rst) // RULE12
        clk_en && !bus16 |=> pin_o[PIN_UPSTB] == $past(port_data[PIN_UPSTB]))
        else $error("upper write strobe driven in eight-bit mode");

    a_lower_strobe_drive: assert property (@(posedge clock) disable iff (sys_rst) // RULE13
        clk_en && ctrl_q[CTRL_LOSTB] |=> pin_o[PIN_LOSTB] == $past(lower_byte_write_strobe))
        else $error("lower write strobe not driven");

endmodule : ebpfs_top

// >>> ebpfs_pkg.sv
// constants shared by the external bus pin function select block
package ebpfs_pkg;

    // ----------------------------------------------------------------
    // pin vector layout
    // ----------------------------------------------------------------
    localparam int PIN_COUNT  = 29;
    localparam int UDATA_BASE = 0;   // upper_data_port_pins, 8 pins
    localparam int MADDR_BASE = 8;   // middle_address_port_pins, 8 pins
    localparam int UADDR_BASE = 16;  // upper address pins, address bits 16..23
    localparam int PIN_READY  = 24;
    localparam int PIN_ACK    = 25;
    localparam int PIN_REQ    = 26;
    localparam int PIN_UPSTB  = 27;
    localparam int PIN_LOSTB  = 28;
    localparam int UA_RX      = 2;   // async_serial_rx_in shares address_bit_eighteen
    localparam int UA_TX      = 3;   // address_bit_nineteen
    localparam int UA_SCK     = 4;   // address_bit_twenty
    localparam int UA_SSI     = 5;   // address_bit_twentyone
    localparam int UA_CAP     = 5;   // capture/timer inputs on upper bits 5..7

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL  = 12'h000;
    localparam logic [11:0] OFS_MADDR = 12'h004;
    localparam logic [11:0] OFS_UADDR = 12'h008;
    localparam logic [11:0] OFS_LEVEL = 12'h00c;
    localparam logic [11:0] OFS_FUNC  = 12'h010;

    // control register fields
    localparam int CTRL_BUS16 = 0;
    localparam int CTRL_READY = 1;
    localparam int CTRL_HOLD  = 2;
    localparam int CTRL_UPSTB = 3;
    localparam int CTRL_LOSTB = 4;
    localparam int CTRL_WIDTH = 5;

    // reset values
    localparam logic [4:0] CTRL_RST  = 5'h00;
    localparam logic [7:0] MADDR_RST = 8'h00;
    localparam logic [7:0] UADDR_RST = 8'h00;

    // ----------------------------------------------------------------
    // bus slave states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        EBPFS_IDLE   = 2'b00,
        EBPFS_ANSWER = 2'b01
    } ebpfs_apb_state_type;

endpackage : ebpfs_pkg

// >>> ebpfs_pin_cell.sv
// one pin output stage: function or port drive, registered
`timescale 1ns/100ps
module ebpfs_pin_cell
    import ebpfs_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // selection
    input  wire logic func_sel,
    input  wire logic func_o,
    input  wire logic func_oe,
    input  wire logic port_o,
    input  wire logic port_oe,
    // pin drive
    output logic      pin_o_q,
    output logic      pin_oe_q
);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pin_o_q  <= 1'b0;
            pin_oe_q <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_o_q  <= func_sel ? func_o  : port_o;   // RULE14
            pin_oe_q <= func_sel ? func_oe : port_oe;  // RULE14
        end
    end

    a_port_follow: assert property (@(posedge clock) disable iff (sys_rst) // RULE14
        clk_en && !func_sel |=> pin_o_q == $past(port_o) && pin_oe_q == $past(port_oe))
        else $error("port pin does not follow port data and direction");

endmodule : ebpfs_pin_cell

// >>> ebpfs_level_sample.sv
// samples every shared pin level once per enabled clock
`timescale 1ns/100ps
module ebpfs_level_sample
    import ebpfs_pkg::*;
#(
    parameter int WIDTH = PIN_COUNT
)
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // pin levels
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_q
);

    // sampled whatever drives the pin, so inputs see their own outputs too
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            level_q <= '0;
        else if (clk_en)
            level_q <= pin_i;  // RULE8
    end

    a_level_track: assert property (@(posedge clock) disable iff (sys_rst) // RULE8
        clk_en |=> level_q == $past(pin_i))
        else $error("pin level not sampled");

endmodule : ebpfs_level_sample

// >>> ebpfs_bus_partner.sv
// behavioural model of the memory and peripherals that share the pins
`timescale 1ns/100ps
module ebpfs_bus_partner
    import ebpfs_pkg::*;
(
    // clock
    input  wire logic                 clock,
    // device side of the pins
    input  wire logic [PIN_COUNT-1:0] pin_o,
    input  wire logic [PIN_COUNT-1:0] pin_oe,
    output logic      [PIN_COUNT-1:0] pin_i,
    // what the external parties drive
    input  wire logic [PIN_COUNT-1:0] ext_val,
    input  wire logic [PIN_COUNT-1:0] ext_oe
);
    // ----------------------------------------------------------------
    // pin resolution
    // ----------------------------------------------------------------
    logic toggle_q;

    initial toggle_q = 1'b0;

    // a floating pin flips every cycle so a stale value never passes
    always @(posedge clock)
    begin
        toggle_q <= ~toggle_q;
    end

    // ready and hold request levels come from ext_val
    // ext drives only pins whose device output is off
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_oe & ext_val)
                 | (~pin_oe & ~ext_oe & {PIN_COUNT{toggle_q}});
endmodule : ebpfs_bus_partner

// >>> tb.sv
// self-checking testbench for the pin function select block
`timescale 1ns/100ps
module tb
    import ebpfs_pkg::*;
;
    typedef struct packed {
        logic [4:0] c;
        logic [7:0] m;
        logic [7:0] u;
        logic [3:0] p;
        logic       d;
    } ebpfs_row_type;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clock = 0, sys_rst = 1, clk_en = 1;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [PIN_COUNT-1:0] pin_i, pin_o, pin_oe, port_level, ext_val = 0, ext_oe = 0;
    logic [PIN_COUNT-1:0] port_data = 29'h15a5a5a5, port_dir = 29'h1fffffff;
    logic [23:8] bus_addr = 16'h5ac3;
    logic [7:0] upper_data_bus_byte_o = 8'h3c, upper_data_bus_byte_i;
    logic upper_data_bus_byte_oe = 0, upper_byte_write_strobe = 0, lower_byte_write_strobe = 1;
    logic bus_hold_acknowledge_out = 1, bus_ready_in, bus_hold_request_in;
    logic async_serial_tx_out = 1, async_serial_tx_oe = 0, async_serial_clock_o = 0;
    logic async_serial_clock_oe = 0, async_serial_clock_i, async_serial_rx_in;
    logic second_sync_serial_unit_clock_o = 1, second_sync_serial_unit_clock_oe = 0;
    logic second_sync_serial_unit_data_o = 0, second_sync_serial_unit_data_oe = 0;
    logic [2:0] capture_timer_in;
    logic err;
    logic [28:0] sel, fo, foe, eoe, xp;
    int mismatches = 0, n_compared = 0;

    localparam ebpfs_row_type ROWS [9] = '{
        '{5'h00, 8'h00, 8'h00, 4'h0, 1'b0}, '{5'h01, 8'h00, 8'h00, 4'h0, 1'b1},
        '{5'h09, 8'ha5, 8'h00, 4'h0, 1'b0}, '{5'h08, 8'h00, 8'h00, 4'h0, 1'b0},
        '{5'h16, 8'h5a, 8'hff, 4'h0, 1'b0}, '{5'h00, 8'h00, 8'hff, 4'hf, 1'b0},
        '{5'h00, 8'h00, 8'h00, 4'h4, 1'b0}, '{5'h00, 8'h00, 8'h10, 4'h4, 1'b0},
        '{5'h00, 8'h00, 8'h00, 4'ha, 1'b0}};

    ebpfs_top uut (.clock, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .pin_i, .pin_o, .pin_oe, .port_data, .port_dir,
        .port_level, .bus_addr, .upper_data_bus_byte_o, .upper_data_bus_byte_oe,
        .upper_data_bus_byte_i, .upper_byte_write_strobe, .lower_byte_write_strobe,
        .bus_hold_acknowledge_out, .bus_ready_in, .bus_hold_request_in,
        .async_serial_tx_out, .async_serial_tx_oe, .async_serial_clock_o,
        .async_serial_clock_oe, .async_serial_clock_i, .async_serial_rx_in,
        .second_sync_serial_unit_clock_o, .second_sync_serial_unit_clock_oe,
        .second_sync_serial_unit_data_o, .second_sync_serial_unit_data_oe,
        .capture_timer_in);

    ebpfs_bus_partner partner (.clock, .pin_o, .pin_oe, .pin_i, .ext_val, .ext_oe);

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic stop_test;
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // apb master: holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready_wait", n, 1);
    endtask : apb

    task automatic cfg(input logic [4:0] c, input logic [7:0] m, input logic [7:0] u);
        apb(1, OFS_CTRL, {27'h0, c});
        apb(1, OFS_MADDR, {24'h0, m});
        apb(1, OFS_UADDR, {24'h0, u});
        repeat (4) @(posedge clock);
    endtask : cfg

    // selection worked out from the pin rules
    task automatic model(input ebpfs_row_type r);
        for (int i = 0; i < 8; i++)
        begin
            {sel[i], fo[i], foe[i]} = {r.c[0], upper_data_bus_byte_o[i], r.d};
            {sel[8+i], fo[8+i], foe[8+i]} = {r.m[i], bus_addr[8+i], 1'b1};
            {sel[16+i], fo[16+i], foe[16+i]} = {r.u[i], bus_addr[16+i], 1'b1};
        end
        if (r.p[0])
            {sel[19], fo[19]} = {1'b1, async_serial_tx_out};
        if (r.p[1])
            {sel[20], fo[20]} = {1'b1, async_serial_clock_o};
        else if (!r.u[4] && r.p[2])
            {sel[20], fo[20]} = {1'b1, second_sync_serial_unit_clock_o};
        if (r.p[3])
            {sel[21], fo[21]} = {1'b1, second_sync_serial_unit_data_o};
        {sel[24], fo[24], foe[24]} = {r.c[1], 2'b00};
        {sel[25], fo[25], foe[25]} = {r.c[2], bus_hold_acknowledge_out, 1'b1};
        {sel[26], fo[26], foe[26]} = {r.c[2], 2'b00};
        {sel[27], fo[27], foe[27]} = {r.c[0] & r.c[3], upper_byte_write_strobe, 1'b1};
        {sel[28], fo[28], foe[28]} = {r.c[4], lower_byte_write_strobe, 1'b1};
        eoe = (sel & foe) | (~sel & port_dir);
        xp = ((sel & fo) | (~sel & port_data)) & eoe;
    endtask : model

    // ----------------------------------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------------------------------
    initial forever #12.5 clock = ~clock;

    initial
    begin
        #(25 * 20000);
        mismatches++;
        stop_test;
    end

    initial
    begin
        repeat (2) @(posedge clock);
        chk("rst_oe", pin_oe, 0);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        chk("rel_oe", pin_oe, port_dir);
        chk("rst_ready", bus_ready_in, 1);
        chk("rst_hold", bus_hold_request_in, 0);
        foreach (ROWS[k])
        begin
            @(posedge clock);
            {second_sync_serial_unit_data_oe, second_sync_serial_unit_clock_oe,
             async_serial_clock_oe, async_serial_tx_oe} <= ROWS[k].p;
            upper_data_bus_byte_oe <= ROWS[k].d;
            cfg(ROWS[k].c, ROWS[k].m, ROWS[k].u);
            model(ROWS[k]);
            chk("pin_oe", pin_oe, eoe);
            chk("pin_o", pin_o & eoe, xp);
            chk("level", port_level & eoe, xp);
            chk("udata_in", upper_data_bus_byte_i & eoe[7:0], xp[7:0]);
            chk("sck_in", async_serial_clock_i & eoe[20], xp[20]);
            apb(0, OFS_FUNC, 0);
            chk("func", rd, sel);
        end
        apb(0, 12'h014, 0);
        chk("unmapped_err", err, 1);
        chk("unmapped_rd", rd, 0);
        apb(1, OFS_FUNC, 32'hffffffff);
        apb(0, OFS_FUNC, 0);
        chk("func_ro", rd, sel);
        {second_sync_serial_unit_data_oe, second_sync_serial_unit_clock_oe,
         async_serial_clock_oe, async_serial_tx_oe} <= 4'h0;
        // ready and hold request follow their pins only when enabled
        ext_oe[24] <= 1'b1;
        ext_oe[26] <= 1'b1;
        for (int v = 0; v < 3; v++)
        begin
            cfg({2'b00, v < 2, v < 2, 1'b0}, 0, 0);
            ext_val[24] <= v[0];
            ext_val[26] <= v[0];
            repeat (4) @(posedge clock);
            chk("ready_in", bus_ready_in, v < 2 ? v[0] : 1'b1);
            chk("hold_in", bus_hold_request_in, v < 2 ? v[0] : 1'b0);
        end
        // input functions see the pin while the address drives it
        cfg(0, 0, 8'h24);
        chk("rx_in", async_serial_rx_in, bus_addr[18]);
        chk("cap_drv", capture_timer_in[0], bus_addr[21]);
        cfg(0, 0, 0);
        port_dir[23:21] <= 3'b000;
        ext_oe[23:21] <= 3'b111;
        for (int v = 2; v < 6; v += 3)
        begin
            ext_val[23:21] <= v[2:0];
            repeat (4) @(posedge clock);
            chk("cap_ext", capture_timer_in, v[2:0]);
            chk("port_in", port_level[23:21], v[2:0]);
        end
        // a low enable must freeze the sampled levels
        clk_en <= 1'b0;
        ext_val[23:21] <= 3'b010;
        repeat (4) @(posedge clock);
        chk("frozen", capture_timer_in, 3'b101);
        clk_en <= 1'b1;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk("rst2_oe", pin_oe, 0);
        apb(0, OFS_UADDR, 0);
        chk("rst2_uaddr", rd, 0);
        stop_test;
    end
endmodule : tb
